// [phy_stats_pkg.sv]
// Notes on behaviour
// - Link rate code 8h..Bh for enabled PHY with link up
// - Generation counter bumps on any config change
// - Generation wraps from FFh to 01h
// - SATA attached: attached reason zero after FIS
// - Virtual PHY: attached reason always zero
// - Reason equals last transmitted identify reason
// - Capture attached identify fields on receipt
// - Local address is own transmitted address
// - Invalid dwords outside reset, saturating
// - Disparity errors only while synced, saturating
// - Count sync losses, saturating
// - Count speed-match reset failures, saturating
// - Descriptor size 0Ch, four descriptors
// - Event sources 01h through 04h
// - Counts from power-on, threshold reads zero
// - Separate read and write command counters
// - Blocks received and transmitted accumulate
// - Unsupported statistics read as zero
// - Idle counter advances only when fully idle
// - Idle time is increments times interval
// - Interval encodes fifty milliseconds
package phy_stats_pkg;

    localparam logic [3:0] RATE_1G5  = 4'h8;
    localparam logic [3:0] RATE_3G0  = 4'h9;
    localparam logic [3:0] RATE_6G0  = 4'hA;
    localparam logic [3:0] RATE_12G0 = 4'hB;
    localparam logic [3:0] RATE_NONE = 4'h0;

    localparam logic [7:0] GEN_UNKNOWN = 8'h00;
    localparam logic [7:0] GEN_MAX     = 8'hFF;
    localparam logic [7:0] GEN_WRAP    = 8'h01;

    localparam logic [7:0]  EVT_DESC_LEN  = 8'h0C;
    localparam logic [7:0]  EVT_DESC_NUM  = 8'h04;
    localparam logic [7:0]  SRC_INVALID   = 8'h01;
    localparam logic [7:0]  SRC_DISPARITY = 8'h02;
    localparam logic [7:0]  SRC_SYNC_LOSS = 8'h03;
    localparam logic [7:0]  SRC_RESET_PRB = 8'h04;
    localparam logic [31:0] PEAK_THRESH   = 32'h0000_0000;

    localparam logic [31:0] INTERVAL_EXP = 32'h0000_0002;
    localparam logic [31:0] INTERVAL_INT = 32'h0000_0005;
    localparam int          INTERVAL_MS  = 50;
    localparam int          CLK_MHZ      = 125;
    localparam int          INTERVAL_CYC = INTERVAL_MS * 1000 * CLK_MHZ;

    // Register byte addresses
    localparam logic [11:0] A_LINK      = 12'h000;
    localparam logic [11:0] A_GEN       = 12'h004;
    localparam logic [11:0] A_ATT_FLAGS = 12'h008;
    localparam logic [11:0] A_ATT_AD_LO = 12'h00C;
    localparam logic [11:0] A_ATT_AD_HI = 12'h010;
    localparam logic [11:0] A_LOC_AD_LO = 12'h014;
    localparam logic [11:0] A_LOC_AD_HI = 12'h018;
    localparam logic [11:0] A_EVT_INFO  = 12'h01C;
    localparam logic [11:0] A_CNT_INV   = 12'h020;
    localparam logic [11:0] A_CNT_DISP  = 12'h024;
    localparam logic [11:0] A_CNT_SYNC  = 12'h028;
    localparam logic [11:0] A_CNT_RST   = 12'h02C;
    localparam logic [11:0] A_THRESH    = 12'h030;
    localparam logic [11:0] A_STAT_BASE = 12'h040;
    localparam logic [11:0] A_ZERO_BASE = 12'h080;
    localparam logic [11:0] A_ZERO_END  = 12'h0A0;
    localparam logic [11:0] A_IV_EXP    = 12'h0A0;
    localparam logic [11:0] A_IV_INT    = 12'h0A4;
    localparam logic [11:0] A_CTRL      = 12'h0A8;

    localparam int CTRL_PHY_EN  = 0;
    localparam int CTRL_VIRTUAL = 1;
    localparam int CTRL_SATA    = 2;
    localparam logic [2:0] CTRL_RESET = 3'h1;

    typedef struct packed {
        logic [2:0]  dev_type;
        logic [3:0]  reason;
        logic [2:0]  init_port;
        logic [2:0]  tgt_port;
        logic [63:0] address;
        logic [7:0]  phy_id;
    } ident_s;

endpackage

// [sat_counter.sv]
`timescale 1ns/100ps
module sat_counter #(
    parameter int W = 32
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         inc,
    input  wire logic [W-1:0] amount,
    input  wire logic         saturate,
    output logic      [W-1:0] count_q
);
    logic [W:0] sum;

    if (W < 8 || W > 64) begin : g_bad_width
        $error("sat_counter width out of range");
    end

    assign sum = {1'b0, count_q} + {1'b0, amount};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= '0;
        end else if (inc) begin
            if (saturate && sum[W]) begin
                count_q <= '1;
            end else begin
                count_q <= sum[W-1:0];
            end
        end
    end
endmodule // sat_counter

// [phy_stats.sv]
`timescale 1ns/100ps
module phy_stats
    import phy_stats_pkg::*;
#(
    parameter int IDLE_TICK_CYC = INTERVAL_CYC,
    parameter int BLK_W         = 16
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        link_up,
    input  wire logic [1:0]  link_speed,
    input  wire logic        cfg_changed,
    input  wire logic        ident_rx_valid,
    input  wire ident_s      ident_rx,
    input  wire logic        ident_tx_valid,
    input  wire ident_s      ident_tx,
    input  wire logic        sata_d2h_fis,
    input  wire logic        in_phy_reset,
    input  wire logic        dword_sync,
    input  wire logic        invalid_dword,
    input  wire logic        disparity_err,
    input  wire logic        sync_lost_restart,
    input  wire logic        speed_match_fail,
    input  wire logic        cmd_read,
    input  wire logic        cmd_write,
    input  wire logic        blk_rx,
    input  wire logic        blk_tx,
    input  wire logic [BLK_W-1:0] blk_count,
    input  wire logic        task_set_empty,
    input  wire logic        lu_busy,
    output logic [3:0]       link_rate_q,
    output logic [7:0]       generation_q
);

    if (IDLE_TICK_CYC < 1) begin : g_bad_tick
        $error("IDLE_TICK_CYC must be positive");
    end
    if (BLK_W < 1 || BLK_W > 32) begin : g_bad_blk
        $error("BLK_W out of range");
    end

    ////////////////////////////////////////////////////////////////////////
    // Control and link status

    logic [2:0]  ctrl_q;
    logic        sata_fis_seen_q;
    ident_s      att_q;
    logic [3:0]  tx_reason_q;
    logic [63:0] local_addr_q;
    logic [3:0]  att_reason;
    logic        apb_wr;
    logic        apb_rd;
    logic        ctrl_wr;

    assign apb_wr = psel && penable && pwrite;
    assign apb_rd = psel && !penable && !pwrite;
    assign ctrl_wr = apb_wr && paddr == A_CTRL;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= CTRL_RESET;
        end else if (ctrl_wr) begin
            ctrl_q <= pwdata[2:0];
        end
    end

    // Rate reads zero whenever the PHY is off or the link is down
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link_rate_q <= RATE_NONE;
        end else if (!ctrl_q[CTRL_PHY_EN] || !link_up) begin
            link_rate_q <= RATE_NONE;
        end else begin
            case (link_speed)
                2'h0:    link_rate_q <= RATE_1G5;
                2'h1:    link_rate_q <= RATE_3G0;
                2'h2:    link_rate_q <= RATE_6G0;
                default: link_rate_q <= RATE_12G0;
            endcase
        end
    end

    // Software writes to control count as a configuration change too
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            generation_q <= GEN_UNKNOWN;
        end else if (cfg_changed || ctrl_wr) begin
            if (generation_q == GEN_MAX) begin
                generation_q <= GEN_WRAP;
            end else begin
                generation_q <= generation_q + 8'h01;
            end
        end
    end

    // Whole frame is taken on the strobe; lines may move right after
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            att_q <= '0;
        end else if (ident_rx_valid) begin
            att_q <= ident_rx;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_reason_q  <= 4'h0;
            local_addr_q <= 64'h0;
        end else if (ident_tx_valid) begin
            tx_reason_q  <= ident_tx.reason;
            local_addr_q <= ident_tx.address;
        end
    end

    // A new link reset restarts the wait for the first FIS
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sata_fis_seen_q <= 1'b0;
        end else if (sata_d2h_fis) begin
            sata_fis_seen_q <= 1'b1;
        end else if (in_phy_reset) begin
            sata_fis_seen_q <= 1'b0;
        end
    end

    // Virtual outranks SATA: a virtual PHY has no attached link
    always_comb begin
        if (ctrl_q[CTRL_VIRTUAL]) begin
            att_reason = 4'h0;
        end else if (ctrl_q[CTRL_SATA] && sata_fis_seen_q) begin
            att_reason = 4'h0;
        end else begin
            att_reason = att_q.reason;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Error event counters

    logic [31:0] cnt_inv;
    logic [31:0] cnt_disp;
    logic [31:0] cnt_sync;
    logic [31:0] cnt_rst;

    // Error counts stick at all ones so an overflow is never hidden
    sat_counter #(.W(32)) u_inv (
        .pclk    (pclk),
        .presetn (presetn),
        .inc     (invalid_dword && !in_phy_reset),
        .amount  (32'h0000_0001),
        .saturate(1'b1),
        .count_q (cnt_inv)
    );

    sat_counter #(.W(32)) u_disp (
        .pclk    (pclk),
        .presetn (presetn),
        .inc     (disparity_err && dword_sync),
        .amount  (32'h0000_0001),
        .saturate(1'b1),
        .count_q (cnt_disp)
    );

    sat_counter #(.W(32)) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .inc     (sync_lost_restart),
        .amount  (32'h0000_0001),
        .saturate(1'b1),
        .count_q (cnt_sync)
    );

    sat_counter #(.W(32)) u_rst (
        .pclk    (pclk),
        .presetn (presetn),
        .inc     (speed_match_fail),
        .amount  (32'h0000_0001),
        .saturate(1'b1),
        .count_q (cnt_rst)
    );

    ////////////////////////////////////////////////////////////////////////
    // Logical unit statistics

    logic [63:0] st_rd_cmd;
    logic [63:0] st_wr_cmd;
    logic [63:0] st_blk_rx;
    logic [63:0] st_blk_tx;
    logic [63:0] st_idle;
    logic [63:0] blk_amt;
    logic [31:0] idle_div_q;
    logic        idle_tick;
    logic        idle_now;

    assign blk_amt  = {{(64-BLK_W){1'b0}}, blk_count};
    // One tick per idle interval; idle time is ticks times interval
    assign idle_now = task_set_empty && !lu_busy;
    assign idle_tick = idle_now && (idle_div_q == 32'(IDLE_TICK_CYC - 1));

    // Partial intervals are kept across busy spells, not discarded
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idle_div_q <= 32'h0;
        end else if (idle_tick) begin
            idle_div_q <= 32'h0;
        end else if (idle_now) begin
            idle_div_q <= idle_div_q + 32'h1;
        end
    end

    // No 64-bit total saturates; command and idle counts wrap only after centuries
    sat_counter #(.W(64)) u_rd (
        .pclk    (pclk),
        .presetn (presetn),
        .inc     (cmd_read),
        .amount  (64'h1),
        .saturate(1'b0),
        .count_q (st_rd_cmd)
    );

    sat_counter #(.W(64)) u_wr (
        .pclk    (pclk),
        .presetn (presetn),
        .inc     (cmd_write),
        .amount  (64'h1),
        .saturate(1'b0),
        .count_q (st_wr_cmd)
    );

    sat_counter #(.W(64)) u_brx (
        .pclk    (pclk),
        .presetn (presetn),
        .inc     (blk_rx),
        .amount  (blk_amt),
        .saturate(1'b0),
        .count_q (st_blk_rx)
    );

    sat_counter #(.W(64)) u_btx (
        .pclk    (pclk),
        .presetn (presetn),
        .inc     (blk_tx),
        .amount  (blk_amt),
        .saturate(1'b0),
        .count_q (st_blk_tx)
    );

    sat_counter #(.W(64)) u_idle (
        .pclk    (pclk),
        .presetn (presetn),
        .inc     (idle_tick),
        .amount  (64'h1),
        .saturate(1'b0),
        .count_q (st_idle)
    );

    ////////////////////////////////////////////////////////////////////////
    // APB read mux

    logic [31:0] rd_data;
    logic        rd_hit;
    logic [63:0] stat_sel;
    logic [2:0]  stat_idx;

    // Low word first; the two halves of a total are not read atomically
    assign stat_idx = paddr[5:3];

    always_comb begin
        case (stat_idx)
            3'h0:    stat_sel = st_rd_cmd;
            3'h1:    stat_sel = st_wr_cmd;
            3'h2:    stat_sel = st_blk_rx;
            3'h3:    stat_sel = st_blk_tx;
            default: stat_sel = st_idle;
        endcase
    end

    always_comb begin
        rd_hit  = 1'b1;
        rd_data = 32'h0;
        if (paddr[1:0] != 2'h0) begin
            rd_hit = 1'b0;
        end else if (paddr >= A_STAT_BASE && paddr < A_ZERO_BASE) begin
            rd_hit = (stat_idx <= 3'h4);
            rd_data = paddr[2] ? stat_sel[63:32] : stat_sel[31:0];
        end else if (paddr >= A_ZERO_BASE && paddr < A_ZERO_END) begin
            rd_data = 32'h0;
        end else begin
            case (paddr)
                A_LINK:      rd_data = {20'h0, tx_reason_q, att_reason,
                                        link_rate_q};
                A_GEN:       rd_data = {24'h0, generation_q};
                A_ATT_FLAGS: rd_data = {12'h0, att_q.phy_id, 1'b0,
                                        att_q.dev_type, 1'b0,
                                        att_q.init_port, 1'b0,
                                        att_q.tgt_port};
                A_ATT_AD_LO: rd_data = att_q.address[31:0];
                A_ATT_AD_HI: rd_data = att_q.address[63:32];
                A_LOC_AD_LO: rd_data = local_addr_q[31:0];
                A_LOC_AD_HI: rd_data = local_addr_q[63:32];
                A_EVT_INFO:  rd_data = {SRC_RESET_PRB[3:0], SRC_SYNC_LOSS[3:0],
                                        SRC_DISPARITY[3:0], SRC_INVALID[3:0],
                                        EVT_DESC_NUM, EVT_DESC_LEN};
                A_CNT_INV:   rd_data = cnt_inv;
                A_CNT_DISP:  rd_data = cnt_disp;
                A_CNT_SYNC:  rd_data = cnt_sync;
                A_CNT_RST:   rd_data = cnt_rst;
                A_THRESH:    rd_data = PEAK_THRESH;
                A_IV_EXP:    rd_data = INTERVAL_EXP;
                A_IV_INT:    rd_data = INTERVAL_INT;
                A_CTRL:      rd_data = {29'h0, ctrl_q};
                default:     rd_hit  = 1'b0;
            endcase
        end
    end

    // Data is latched in setup, so the access phase always ends in one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            if (psel && !penable) begin
                prdata  <= apb_rd && rd_hit ? rd_data : 32'h0;
                pslverr <= !rd_hit || (pwrite && paddr != A_CTRL);
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

endmodule // phy_stats

// [phy_stats_monitor.sv]
`timescale 1ns/100ps
module phy_stats_monitor
    import phy_stats_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        link_up,
    input wire logic [1:0]  link_speed,
    input wire logic        cfg_changed,
    input wire logic [3:0]  link_rate_q,
    input wire logic [7:0]  generation_q
);
    logic wr_ctrl;
    logic rd_ok;
    assign wr_ctrl = psel && penable && pready && pwrite && paddr == A_CTRL;
    assign rd_ok   = psel && penable && pready && !pwrite;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////
    property p_ready;
        psel && !penable |=> pready ##1 !pready;
    endproperty
    a_ready: assert property (p_ready) else $error("no single ready pulse");
    property p_rate;
        1'b1 |=> link_rate_q == 4'h0 ||
            ($past(link_up) && link_rate_q == {2'b10, $past(link_speed)});
    endproperty
    a_rate: assert property (p_rate) else $error("bad rate code");
    property p_gen_step;
        $changed(generation_q) && $past(generation_q) != 8'hFF
            |-> generation_q == $past(generation_q) + 8'h01;
    endproperty
    a_gen_step: assert property (p_gen_step) else $error("gen step");
    property p_gen_wrap;
        $past(generation_q) == 8'hFF && $changed(generation_q)
            |-> generation_q == 8'h01;
    endproperty
    a_gen_wrap: assert property (p_gen_wrap) else $error("gen wrap");
    property p_gen_known;
        generation_q != 8'h00 |=> generation_q != 8'h00;
    endproperty
    a_gen_known: assert property (p_gen_known) else $error("gen zero");
    // Write lands one or two edges after its cause
    property p_gen_cause;
        $changed(generation_q) |-> $past(cfg_changed) || $past(wr_ctrl)
            || $past(cfg_changed, 2) || $past(wr_ctrl, 2);
    endproperty
    a_gen_cause: assert property (p_gen_cause) else $error("gen cause");
    property p_zero;
        rd_ok && paddr >= A_ZERO_BASE && paddr < A_ZERO_END
            |-> prdata == 32'h0 && !pslverr;
    endproperty
    a_zero: assert property (p_zero) else $error("stat not zero");
    property p_thresh;
        rd_ok && paddr == A_THRESH |-> prdata == 32'h0;
    endproperty
    a_thresh: assert property (p_thresh) else $error("threshold");
    property p_evt;
        rd_ok && paddr == A_EVT_INFO |-> prdata == 32'h4321_040C;
    endproperty
    a_evt: assert property (p_evt) else $error("event info");
    property p_ival;
        rd_ok && (paddr == A_IV_EXP || paddr == A_IV_INT)
            |-> prdata == (paddr == A_IV_EXP ? 32'h2 : 32'h5);
    endproperty
    a_ival: assert property (p_ival) else $error("interval");
endmodule // phy_stats_monitor

bind phy_stats phy_stats_monitor u_mon (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link_up(link_up), .link_speed(link_speed),
    .cfg_changed(cfg_changed), .link_rate_q(link_rate_q),
    .generation_q(generation_q)
);

// [sas_peer.sv]
`timescale 1ns/100ps
module sas_peer
    import phy_stats_pkg::*;
(
    input  wire logic pclk,
    output logic       link_up,
    output logic [1:0] link_speed,
    output logic       ident_rx_valid,
    output ident_s     ident_rx,
    output logic       ident_tx_valid,
    output ident_s     ident_tx,
    output logic       sata_d2h_fis,
    output logic       in_phy_reset,
    output logic       dword_sync,
    output logic       invalid_dword,
    output logic       disparity_err,
    output logic       sync_lost_restart,
    output logic       speed_match_fail
);
    initial begin
        {link_up, ident_rx_valid, ident_tx_valid, sata_d2h_fis} = '0;
        {in_phy_reset, dword_sync, link_speed} = '0;
        {speed_match_fail, sync_lost_restart, disparity_err} = '0;
        invalid_dword = 1'b0;
        ident_rx = '0;
        ident_tx = '0;
    end
    task automatic set_lvl(input logic up, input logic [1:0] spd,
                           input logic rst, input logic sync);
        @(posedge pclk);
        link_up <= up;
        link_speed <= spd;
        in_phy_reset <= rst;
        dword_sync <= sync;
    endtask
    // One event per cycle the strobe is high
    task automatic errs(input logic [3:0] k, input int n);
        repeat (n) begin
            @(posedge pclk);
            {speed_match_fail, sync_lost_restart, disparity_err,
             invalid_dword} <= k;
        end
        @(posedge pclk);
        {speed_match_fail, sync_lost_restart, disparity_err,
         invalid_dword} <= 4'h0;
    endtask
    // Frame lines flip after the strobe so stale capture shows
    task automatic send_ident(input ident_s rx, input ident_s tx);
        @(posedge pclk);
        ident_rx <= rx;
        ident_tx <= tx;
        ident_rx_valid <= 1'b1;
        ident_tx_valid <= 1'b1;
        @(posedge pclk);
        ident_rx <= ~rx;
        ident_tx <= ~tx;
        ident_rx_valid <= 1'b0;
        ident_tx_valid <= 1'b0;
    endtask
    task automatic fis;
        @(posedge pclk);
        sata_d2h_fis <= 1'b1;
        @(posedge pclk);
        sata_d2h_fis <= 1'b0;
    endtask
endmodule // sas_peer

// [tb_top.sv]
`timescale 1ns/100ps
module tb_top
    import phy_stats_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic        link_up, cfg_changed, ident_rx_valid, ident_tx_valid;
    logic        sata_d2h_fis, in_phy_reset, dword_sync, invalid_dword;
    logic        disparity_err, sync_lost_restart, speed_match_fail;
    logic        cmd_read, cmd_write, blk_rx, blk_tx, task_set_empty, lu_busy;
    logic [1:0]  link_speed;
    logic [15:0] blk_count;
    logic [3:0]  link_rate_q;
    logic [7:0]  generation_q;
    ident_s      ident_rx, ident_tx, irx, itx;
    int          fails, checked, i;

    phy_stats #(.IDLE_TICK_CYC(10)) dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .link_up, .link_speed, .cfg_changed,
        .ident_rx_valid, .ident_rx, .ident_tx_valid, .ident_tx,
        .sata_d2h_fis, .in_phy_reset, .dword_sync, .invalid_dword,
        .disparity_err, .sync_lost_restart, .speed_match_fail, .cmd_read,
        .cmd_write, .blk_rx, .blk_tx, .blk_count, .task_set_empty, .lu_busy,
        .link_rate_q, .generation_q
    );
    sas_peer peer (
        .pclk, .link_up, .link_speed, .ident_rx_valid, .ident_rx,
        .ident_tx_valid, .ident_tx, .sata_d2h_fis, .in_phy_reset,
        .dword_sync, .invalid_dword, .disparity_err, .sync_lost_restart,
        .speed_match_fail
    );
    ////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %0h expected %0h",
                     $time, got, exp);
        end
    endtask
    // Master waits for ready with no assumed latency
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] rd_v,
                       output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd_v = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0, r, e);
        chk({e, r}, {1'b0, x});
    endtask
    task automatic rd64(input logic [11:0] a, input logic [63:0] x);
        rd(a, x[31:0]);
        rd(a + 12'h004, x[63:32]);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic x);
        apb(1'b1, a, d, r, e);
        chk(e, x);
    endtask
    task automatic pulse(input logic [4:0] k, input logic [15:0] c);
        @(posedge pclk);
        {blk_tx, blk_rx, cmd_write, cmd_read, cfg_changed} <= k;
        blk_count <= c;
        @(posedge pclk);
        {blk_tx, blk_rx, cmd_write, cmd_read, cfg_changed} <= 5'h00;
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge pclk);
        fails++;
        stop_test;
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {cmd_read, cmd_write, blk_rx, blk_tx, cfg_changed} = '0;
        {task_set_empty, lu_busy, blk_count} = '0;
        irx = '{3'h1, 4'h5, 3'h2, 3'h4, 64'h1122_3344_5566_7788, 8'h3C};
        itx = '{3'h0, 4'h9, 3'h0, 3'h1, 64'hA0B0_C0D0_E0F0_0102, 8'h00};
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        chk(generation_q, 8'h00);
        rd(A_CNT_INV, 32'h0);
        rd(A_THRESH, 32'h0);
        rd(A_EVT_INFO, 32'h4321_040C);
        rd(A_IV_EXP, 32'h2);
        rd(A_IV_INT, 32'h5);
        for (i = 0; i < 8; i++) rd(A_ZERO_BASE + 12'(4 * i), 32'h0);
        for (i = 0; i < 4; i++) begin
            peer.set_lvl(1'b0, 2'h0, 1'b0, 1'b1);
            peer.set_lvl(1'b1, i[1:0], 1'b0, 1'b1);
            repeat (3) @(posedge pclk);
            chk(link_rate_q, 4'h8 + i);
        end
        wr(A_CTRL, 32'h0, 1'b0);
        repeat (3) @(posedge pclk);
        chk({generation_q, link_rate_q}, 12'h010);
        wr(A_CTRL, 32'h1, 1'b0);
        wr(A_GEN, 32'hFF, 1'b1);
        apb(1'b0, 12'hFFC, 32'h0, r, e);
        chk({e, r}, {1'b1, 32'h0});
        for (i = 0; i < 253; i++) pulse(5'h01, 16'h0);
        repeat (3) @(posedge pclk);
        chk(generation_q, 8'hFF);
        pulse(5'h01, 16'h0);
        repeat (3) @(posedge pclk);
        chk(generation_q, 8'h01);
        peer.send_ident(irx, itx);
        rd64(A_ATT_AD_LO, irx.address);
        rd64(A_LOC_AD_LO, itx.address);
        rd(A_ATT_FLAGS, {12'h0, irx.phy_id, 1'b0, irx.dev_type, 1'b0,
                         irx.init_port, 1'b0, irx.tgt_port});
        rd(A_LINK, 32'h95B);
        wr(A_CTRL, 32'h3, 1'b0);
        rd(A_LINK, 32'h90B);
        wr(A_CTRL, 32'h5, 1'b0);
        peer.send_ident(irx, itx);
        rd(A_LINK, 32'h95B);
        peer.fis;
        rd(A_LINK, 32'h90B);
        wr(A_CTRL, 32'h1, 1'b0);
        // Dwords inside reset and disparity errors out of sync must not count
        peer.set_lvl(1'b1, 2'h3, 1'b1, 1'b1);
        peer.errs(4'h1, 3);
        peer.set_lvl(1'b1, 2'h3, 1'b0, 1'b0);
        peer.errs(4'h2, 4);
        peer.errs(4'h1, 5);
        peer.set_lvl(1'b1, 2'h3, 1'b0, 1'b1);
        peer.errs(4'h2, 6);
        peer.errs(4'h4, 7);
        peer.errs(4'h8, 2);
        rd(A_CNT_INV, 32'd5);
        rd(A_CNT_DISP, 32'd6);
        rd(A_CNT_SYNC, 32'd7);
        rd(A_CNT_RST, 32'd2);
        for (i = 0; i < 3; i++) pulse(5'h02, 16'h0);
        for (i = 0; i < 2; i++) pulse(5'h04, 16'h0);
        for (i = 0; i < 2; i++) pulse(5'h08, 16'h7);
        pulse(5'h10, 16'h9);
        rd64(A_STAT_BASE, 64'd3);
        rd64(A_STAT_BASE + 12'h008, 64'd2);
        rd64(A_STAT_BASE + 12'h010, 64'd14);
        rd64(A_STAT_BASE + 12'h018, 64'd9);
        // 105 idle cycles at 10 a tick: ten ticks, five cycles left over
        task_set_empty <= 1'b1;
        repeat (105) @(posedge pclk);
        task_set_empty <= 1'b0;
        rd64(A_STAT_BASE + 12'h020, 64'd10);
        task_set_empty <= 1'b1;
        lu_busy <= 1'b1;
        repeat (60) @(posedge pclk);
        rd64(A_STAT_BASE + 12'h020, 64'd10);
        stop_test;
    end
endmodule // tb_top
